// *** src/power_state_defines.vh ***
// Constants for the power-state and wake-up controller
`ifndef POWER_STATE_DEFINES_VH
`define POWER_STATE_DEFINES_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define OFS_WAKE_LEVEL      8'h00
`define OFS_WAKE_ENABLE     8'h04
`define OFS_XTAL_CTRL       8'h08
`define OFS_PWR_CMD         8'h0C
`define OFS_PWR_STATUS      8'h10
// ****************************************
// Fields and reset values
// ****************************************
`define WAKE_PIN_COUNT      5
`define RST_WAKE_LEVEL      32'h0000_0000
`define RST_WAKE_ENABLE     32'h0000_0007
`define RST_XTAL_CTRL       32'h0000_0000
`define FAST_XTAL_BIT       0
`define LOW_ONLY_MASK       5'h07
`define CMD_SLEEP_BIT       0
`define CMD_STANDBY_BIT     1
// ****************************************
// States
// ****************************************
`define ST_RESET            3'h0
`define ST_PREACTIVE        3'h1
`define ST_ACTIVE           3'h2
`define ST_SLEEP            3'h3
`define ST_STANDBY          3'h4
// ****************************************
// Timing and AXI response codes
// ****************************************
`define CLK_HZ              10000000
`define CORE_RST_NS         1000
`define CORE_RST_CYCLES     ((`CORE_RST_NS * (`CLK_HZ / 1000000)) / 1000)
`define AXI_OKAY            2'h0
`define AXI_SLVERR          2'h2
`endif

// *** src/pin_sync.v ***
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_r;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_r <= {WIDTH{1'b0}};
      syncOut  <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end
endmodule
`default_nettype wire

// *** src/pulse_stretch.v ***
// Fixed-length pulse generator started by a one-cycle trigger
`timescale 1ns/1ps
`default_nettype none
module pulse_stretch #(
  parameter LENGTH = 1
) (
  input  wire sys_clk,
  input  wire rst,
  input  wire trigger,
  output reg  pulseOut
);
  reg [15:0] count_r;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      count_r  <= 16'h0000;
      pulseOut <= 1'b0;
    end
    else if (trigger)
    begin
      count_r  <= LENGTH[15:0];
      pulseOut <= 1'b1;
    end
    else if (count_r > 16'h0001)
    begin
      count_r  <= count_r - 16'h0001;
      pulseOut <= 1'b1;
    end
    else
    begin
      count_r  <= 16'h0000;
      pulseOut <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** src/power_state_wakeup_ctrl.v ***
// Power-state sequencer with wake-up pin logic and AXI4-Lite registers
// Contract
// - After power-on reset, preactive comes first, supplies stable.
// - Preactive uses the internal 16 MHz fast oscillator.
// - Preactive uses the internal 32.768 kHz RC low-frequency clock.
// - Active uses the crystal; internal fast oscillator off.
// - Standby keeps retention supply only, LF clock off, enabled pins wake.
// - Sleep keeps retention supply and the LF oscillator running.
// - Sleep ends on an enabled pin at level or radio timer expiry.
// - Both RAM banks stay in retention in every low-power state.
// - Wake-level field bits 4:0, reset zero, 0 low 1 high.
// - Wake-enable field bits 4:0, reset enables first three pins.
// - First three pins wake on low only, internal pull-up on.
// - Fast osc only preactive; crystal active; LF clock except reset/standby. Code also enables the crystal in preactive.
// - Retention regulator on except reset; others on from preactive up.
// - Offset 0x08 holds crystal frequency indication, reset zero.
// - Bit 0 selects 16 MHz (0) or 32 MHz (1); rest reserved.
// - Leaving sleep or standby issues a core reset pulse.
`timescale 1ns/1ps
`default_nettype none
`include "power_state_defines.vh"
module power_state_wakeup_ctrl #(
  parameter PINS = `WAKE_PIN_COUNT
) (
  input  wire            sys_clk,
  input  wire            rst,
  // AXI4-Lite slave
  input  wire [7:0]      s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output reg             s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output reg             s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [7:0]      s_axi_araddr,
  input  wire            s_axi_arvalid,
  output reg             s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  // Pins and analog handshakes
  input  wire [PINS-1:0] wakePins,
  input  wire            radioTimerWake,
  input  wire            crystalStable,
  // Supply and clock enables, core reset and power state
  output reg             retentionRegulatorEn,
  output reg             mainCoreRegulatorEn,
  output reg             digitalHighRegulatorEn,
  output reg             digitalLowRegulatorEn,
  output reg             switchingConverterEn,
  output reg             brownoutDetectorEn,
  output reg             internalFastOscEn,
  output reg             crystalOscEn,
  output reg             lowFreqClockEn,
  output reg             ramBankRetainA,
  output reg             ramBankRetainB,
  output reg  [2:0]      lowLevelPullupEn,
  output reg             fastCrystalSelect,
  output reg             coreReset,
  output reg  [2:0]      powerState
);
  // ****************************************
  // Registers
  // ****************************************
  reg  [31:0]     wakeLevel_r;
  reg  [31:0]     wakeEnable_r;
  reg  [31:0]     xtalCtrl_r;
  reg  [2:0]      state_r;
  reg  [2:0]      state_nxt;
  reg             wakeEvent_r;
  reg  [7:0]      awAddr_r;
  reg  [31:0]     wData_r;
  reg  [3:0]      wStrb_r;
  reg             awHeld_r;
  reg             wHeld_r;
  reg  [1:0]      cmdReq_r;
  wire [PINS-1:0] pinSync;
  wire            radioSync;
  wire            xtalSync;
  wire            rstPulse;
  wire            wakeReq;
  wire            lowPower;
  wire            doWrite;

  // ****************************************
  // Helpers
  // ****************************************
  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    integer i;
    begin
      mergeBytes = oldVal;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
    end
  endfunction

  function isMapped;
    input [7:0] addr;
    begin
      isMapped = (addr == `OFS_WAKE_LEVEL) || (addr == `OFS_WAKE_ENABLE) ||
                 (addr == `OFS_XTAL_CTRL) || (addr == `OFS_PWR_CMD) ||
                 (addr == `OFS_PWR_STATUS);
    end
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  pin_sync #(
    .WIDTH (PINS + 2)
  ) uSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({radioTimerWake, crystalStable, wakePins}),
    .syncOut ({radioSync, xtalSync, pinSync})
  );

  // ****************************************
  // Wake detection
  // ****************************************
  // First three pins are forced to low-level sensing whatever the register
  wire [PINS-1:0] effLevel = wakeLevel_r[PINS-1:0] &
                             ~`LOW_ONLY_MASK;
  wire [PINS-1:0] pinHit = wakeEnable_r[PINS-1:0] &
                           ~(pinSync ^ effLevel);
  assign lowPower = (state_r == `ST_SLEEP) || (state_r == `ST_STANDBY);
  // Radio timers only count in sleep; their clock is off in standby
  assign wakeReq = lowPower && ((|pinHit) ||
                   (state_r == `ST_SLEEP && radioSync));

  // ****************************************
  // State machine
  // ****************************************
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `ST_RESET:     state_nxt = `ST_PREACTIVE;
      `ST_PREACTIVE: if (xtalSync) state_nxt = `ST_ACTIVE;
      `ST_ACTIVE:
      begin
        if (cmdReq_r[`CMD_STANDBY_BIT])
          state_nxt = `ST_STANDBY;
        else if (cmdReq_r[`CMD_SLEEP_BIT])
          state_nxt = `ST_SLEEP;
      end
      `ST_SLEEP:     if (wakeReq) state_nxt = `ST_PREACTIVE;
      `ST_STANDBY:   if (wakeReq) state_nxt = `ST_PREACTIVE;
      default:       state_nxt = `ST_RESET;
    endcase
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r     <= `ST_RESET;
      wakeEvent_r <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      wakeEvent_r <= lowPower && wakeReq;
    end
  end

  pulse_stretch #(
    .LENGTH (`CORE_RST_CYCLES)
  ) uCoreRst (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .trigger  (wakeEvent_r),
    .pulseOut (rstPulse)
  );

  // ****************************************
  // Supply and clock enables per state, plus core reset and state output
  // ****************************************
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      retentionRegulatorEn   <= 1'b0;
      mainCoreRegulatorEn    <= 1'b0;
      digitalHighRegulatorEn <= 1'b0;
      digitalLowRegulatorEn  <= 1'b0;
      switchingConverterEn   <= 1'b0;
      brownoutDetectorEn     <= 1'b0;
      internalFastOscEn      <= 1'b0;
      crystalOscEn           <= 1'b0;
      lowFreqClockEn         <= 1'b0;
      ramBankRetainA         <= 1'b1;
      ramBankRetainB         <= 1'b1;
      lowLevelPullupEn       <= 3'h7;
      fastCrystalSelect      <= 1'b0;
      coreReset              <= 1'b1;
      powerState             <= `ST_RESET;
    end
    else
    begin
      retentionRegulatorEn   <= state_r != `ST_RESET;
      mainCoreRegulatorEn    <= state_r == `ST_PREACTIVE ||
                                state_r == `ST_ACTIVE;
      digitalHighRegulatorEn <= state_r == `ST_PREACTIVE ||
                                state_r == `ST_ACTIVE;
      digitalLowRegulatorEn  <= state_r == `ST_PREACTIVE ||
                                state_r == `ST_ACTIVE;
      switchingConverterEn   <= state_r == `ST_PREACTIVE ||
                                state_r == `ST_ACTIVE;
      brownoutDetectorEn     <= state_r == `ST_PREACTIVE ||
                                state_r == `ST_ACTIVE;
      internalFastOscEn      <= state_r == `ST_PREACTIVE;
      crystalOscEn           <= state_r == `ST_ACTIVE ||
                                state_r == `ST_PREACTIVE;
      lowFreqClockEn         <= state_r != `ST_RESET &&
                                state_r != `ST_STANDBY;
      ramBankRetainA         <= 1'b1;
      ramBankRetainB         <= 1'b1;
      lowLevelPullupEn       <= 3'h7;
      fastCrystalSelect      <= xtalCtrl_r[`FAST_XTAL_BIT];
      coreReset              <= rstPulse || state_r == `ST_RESET;
      powerState             <= state_r;
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= 8'h00;
      wData_r       <= 32'h0000_0000;
      wStrb_r       <= 4'h0;
      wakeLevel_r   <= `RST_WAKE_LEVEL;
      wakeEnable_r  <= `RST_WAKE_ENABLE;
      xtalCtrl_r    <= `RST_XTAL_CTRL;
      cmdReq_r      <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      // A command is consumed once the sequencer leaves active
      if (state_r != `ST_ACTIVE)
        cmdReq_r <= 2'h0;
      if (doWrite)
      begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr_r) ? `AXI_OKAY : `AXI_SLVERR;
        case (awAddr_r)
          `OFS_WAKE_LEVEL:
            wakeLevel_r <= mergeBytes(wakeLevel_r, wData_r, wStrb_r);
          `OFS_WAKE_ENABLE:
            wakeEnable_r <= mergeBytes(wakeEnable_r, wData_r, wStrb_r);
          `OFS_XTAL_CTRL:
            xtalCtrl_r <= mergeBytes(xtalCtrl_r, wData_r, wStrb_r);
          `OFS_PWR_CMD:
            if (wStrb_r[0] && state_r == `ST_ACTIVE)
              cmdReq_r <= wData_r[1:0];
          default:
            cmdReq_r <= cmdReq_r;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= isMapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
        case (s_axi_araddr)
          `OFS_WAKE_LEVEL:  s_axi_rdata <= wakeLevel_r;
          `OFS_WAKE_ENABLE: s_axi_rdata <= wakeEnable_r;
          `OFS_XTAL_CTRL:   s_axi_rdata <= xtalCtrl_r;
          `OFS_PWR_CMD:     s_axi_rdata <= {30'h0000_0000, cmdReq_r};
          `OFS_PWR_STATUS:
            s_axi_rdata <= {19'h0_0000, xtalSync, 3'h0, pinSync,
                            1'b0, state_r};
          default:          s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verification/power_state_wakeup_ctrl_properties.sv ***
// Port-level checks for the power-state and wake-up controller
`timescale 1ns/1ps
`default_nettype none
module power_state_wakeup_ctrl_properties (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       crystalStable,
  input wire logic       retentionRegulatorEn,
  input wire logic       mainCoreRegulatorEn,
  input wire logic       switchingConverterEn,
  input wire logic       brownoutDetectorEn,
  input wire logic       internalFastOscEn,
  input wire logic       crystalOscEn,
  input wire logic       lowFreqClockEn,
  input wire logic       ramBankRetainA,
  input wire logic       ramBankRetainB,
  input wire logic [2:0] lowLevelPullupEn,
  input wire logic       coreReset,
  input wire logic [2:0] powerState
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_firstPre;
    $past(powerState) == 3'h0 && powerState != 3'h0 |-> powerState == 3'h1;
  endproperty
  a_firstPre: assert property (p_firstPre)
    else $error("first state after reset is not preactive");
  property p_preClk;
    powerState == 3'h1 |-> internalFastOscEn && lowFreqClockEn;
  endproperty
  a_preClk: assert property (p_preClk)
    else $error("preactive clocks wrong");
  property p_actClk;
    powerState == 3'h2 |-> crystalOscEn && !internalFastOscEn
      && lowFreqClockEn;
  endproperty
  a_actClk: assert property (p_actClk)
    else $error("active clocks wrong");
  property p_standby;
    powerState == 3'h4 |-> retentionRegulatorEn && !lowFreqClockEn
      && !crystalOscEn && !internalFastOscEn;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby enables wrong");
  property p_sleep;
    powerState == 3'h3 |-> retentionRegulatorEn && lowFreqClockEn
      && !crystalOscEn;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep enables wrong");
  property p_keep;
    ramBankRetainA && ramBankRetainB && lowLevelPullupEn == 3'h7;
  endproperty
  a_keep: assert property (p_keep)
    else $error("retention or pull-up dropped");
  property p_supply;
    {mainCoreRegulatorEn, switchingConverterEn, brownoutDetectorEn}
      == {3{powerState == 3'h1 || powerState == 3'h2}};
  endproperty
  a_supply: assert property (p_supply)
    else $error("main supplies do not follow state");
  property p_toActive;
    powerState == 3'h2 && $past(powerState) == 3'h1 |-> $past(crystalStable, 2);
  endproperty
  a_toActive: assert property (p_toActive)
    else $error("active entered without stable crystal");
  property p_wakeRst;
    powerState == 3'h1 && ($past(powerState) == 3'h3 ||
      $past(powerState) == 3'h4) |-> ##[0:3] coreReset;
  endproperty
  a_wakeRst: assert property (p_wakeRst)
    else $error("no core reset on wake");
  property p_rstLen;
    $rose(coreReset) |-> coreReset [*8];
  endproperty
  a_rstLen: assert property (p_rstLen)
    else $error("core reset pulse too short");
endmodule
bind power_state_wakeup_ctrl power_state_wakeup_ctrl_properties u_props (
  .sys_clk, .rst, .crystalStable, .retentionRegulatorEn, .mainCoreRegulatorEn,
  .switchingConverterEn, .brownoutDetectorEn, .internalFastOscEn,
  .crystalOscEn, .lowFreqClockEn, .ramBankRetainA, .ramBankRetainB,
  .lowLevelPullupEn, .coreReset, .powerState);
`default_nettype wire

// *** verification/wake_pin_driver.sv ***
// Board circuitry model driving the five wake pins
`timescale 1ns/1ps
`default_nettype none
module wake_pin_driver (
  input  wire logic [4:0] levelSel,
  input  wire logic [2:0] pullupEn,
  input  wire logic [4:0] wakeReq,
  output var  logic [4:0] wakePins
);
  logic [4:0] idleLvl;
  // Idle pins rest away from their wake level; a..c rely on the pull-up
  assign idleLvl = {~levelSel[4:3], pullupEn};
  // Pins d and e are always driven, never left floating
  assign wakePins = wakeReq ^ idleLvl;
endmodule
`default_nettype wire

// *** verification/power_state_wakeup_ctrl_tb.sv ***
// Self-checking bench for the power-state and wake-up controller
`timescale 1ns/1ps
`default_nettype none
module power_state_wakeup_ctrl_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdVal;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0]  wakePins, wakeReq = 5'h0, levelSel = 5'h0;
  logic        radioTimerWake = 1'b0, crystalStable = 1'b0;
  logic        retentionRegulatorEn, mainCoreRegulatorEn, coreReset;
  logic        digitalHighRegulatorEn, digitalLowRegulatorEn;
  logic        switchingConverterEn, brownoutDetectorEn, fastCrystalSelect;
  logic        internalFastOscEn, crystalOscEn, lowFreqClockEn;
  logic        ramBankRetainA, ramBankRetainB;
  logic [2:0]  lowLevelPullupEn, powerState;
  int          badCount = 0, numChecks = 0;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, e;
    logic [1:0] r;} row_t;
  // Writes store all 32 bits unmasked; the table only writes values with reserved bits at zero
  row_t rows [7] = '{'{1'b0, 8'h00, 32'h0, 32'h0, 2'h0},
    '{1'b0, 8'h04, 32'h0, 32'h7, 2'h0}, '{1'b0, 8'h08, 32'h0, 32'h0, 2'h0},
    '{1'b1, 8'h00, 32'h1f, 32'h1f, 2'h0}, '{1'b1, 8'h04, 32'h18, 32'h18, 2'h0},
    '{1'b1, 8'h08, 32'h1, 32'h1, 2'h0}, '{1'b1, 8'h20, 32'hff, 32'h0, 2'h2}};
  power_state_wakeup_ctrl u_dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wakePins, .radioTimerWake, .crystalStable, .retentionRegulatorEn,
    .mainCoreRegulatorEn, .digitalHighRegulatorEn, .digitalLowRegulatorEn,
    .switchingConverterEn, .brownoutDetectorEn, .internalFastOscEn,
    .crystalOscEn, .lowFreqClockEn, .ramBankRetainA, .ramBankRetainB,
    .lowLevelPullupEn, .fastCrystalSelect, .coreReset, .powerState);
  wake_pin_driver u_pins (.levelSel, .pullupEn(lowLevelPullupEn), .wakeReq,
    .wakePins);
  always #50 sys_clk = ~sys_clk;
  // ****************************************
  // Bus and checking tasks
  // ****************************************
  task automatic check(input string n, input logic [31:0] s, e);
    numChecks++;
    if (s !== e)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  task automatic axiRd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdVal = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic waitState(input logic [2:0] s);
    int n;
    n = 0;
    while (powerState !== s && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("powerState", powerState, s);
  endtask
  // Core reset shows one edge after the wake state appears, lasts 10 cycles
  task automatic checkPulse();
    @(posedge sys_clk);
    check("coreReset", coreReset, 1'b1);
    repeat (9) @(posedge sys_clk);
    check("coreResetLen", coreReset, 1'b1);
    @(posedge sys_clk);
    check("coreResetEnd", coreReset, 1'b0);
  endtask
  task automatic stopTest();
    $display("Checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Whole run needs a few hundred cycles; 20000 leaves ample margin
  initial
  begin
    #2000000;
    badCount++;
    stopTest();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    waitState(3'h1);
    check("preEn", {internalFastOscEn, lowFreqClockEn,
      digitalHighRegulatorEn, digitalLowRegulatorEn}, 4'hf);
    foreach (rows[i])
    begin
      if (rows[i].w)
      begin
        axiWr(rows[i].a, rows[i].d);
        check("bresp", rsp, rows[i].r);
      end
      axiRd(rows[i].a);
      check("rdata", rdVal, rows[i].e);
      check("rresp", rsp, rows[i].r);
    end
    check("xtalSel", fastCrystalSelect, 1'b1);
    $display("Register table done");
    crystalStable <= 1'b1;
    waitState(3'h2);
    check("actEn", {internalFastOscEn, crystalOscEn}, 2'h1);
    levelSel <= 5'h1f;
    axiWr(8'h04, 32'hf);
    axiWr(8'h0c, 32'h1);
    waitState(3'h3);
    check("sleepEn", {lowFreqClockEn, retentionRegulatorEn, mainCoreRegulatorEn,
      crystalOscEn, ramBankRetainA}, 5'h19);
    repeat (20) @(posedge sys_clk);
    check("sleepHold", powerState, 3'h3);
    wakeReq <= 5'h08;
    waitState(3'h1);
    checkPulse();
    wakeReq <= 5'h0;
    waitState(3'h2);
    $display("Pin wake from sleep done");
    axiWr(8'h0c, 32'h2);
    waitState(3'h4);
    check("stbyEn", {lowFreqClockEn, retentionRegulatorEn,
      digitalHighRegulatorEn, digitalLowRegulatorEn}, 4'h4);
    radioTimerWake <= 1'b1;
    wakeReq <= 5'h10;
    repeat (20) @(posedge sys_clk);
    check("stbyHold", powerState, 3'h4);
    wakeReq <= 5'h01;
    waitState(3'h1);
    checkPulse();
    wakeReq <= 5'h0;
    radioTimerWake <= 1'b0;
    waitState(3'h2);
    $display("Standby wake done");
    axiWr(8'h0c, 32'h1);
    waitState(3'h3);
    radioTimerWake <= 1'b1;
    waitState(3'h1);
    checkPulse();
    radioTimerWake <= 1'b0;
    $display("Radio wake done");
    rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    axiRd(8'h04);
    check("enableRst", rdVal, 32'h7);
    check("xtalRst", fastCrystalSelect, 1'b0);
    $display("Second reset done");
    stopTest();
  end
endmodule
`default_nettype wire
